// ### latched_piso_shift_register.sv
// Eight-bit input latch feeding an eight-bit serial-out shift register.
// Stage 0 takes the serial bit; stage W-1 drives the serial output.
// Assumes all pins are asynchronous to ref_clk and held for several ref_clk periods.
`timescale 1ns/1ps
// Function
// - Latch strobe rising edge captures parallel inputs
// - Shift mode: shift edge loads serial bit
// - Load mode ignores the serial input bit
// - Load mode copies latch into stages, no shift
// - Low clear input zeroes all stages
// - Stage clear leaves the latch untouched
// - Shift edge advances each stage one place
// - Serial output shows the last stage
module latched_piso_shift_register #(
    parameter int unsigned W = piso_latch_pkg::DATA_W
) (
    input  wire logic          ref_clk,
    input  wire logic          reset,
    input  wire logic [W-1:0]  parallel_in,
    input  wire logic          serial_bit_in,
    input  wire logic          shift_mode,
    input  wire logic          latch_strobe,
    input  wire logic          shift_clk_in,
    input  wire logic          clear_n,
    output logic               serial_bit_out
);
    import piso_latch_pkg::*;

    // ****************************************
    // Pin synchronisation
    // ****************************************
    // Every pin, clear_n included, crosses on two flops before any logic reads it.
    // The clear therefore reaches the stages three edges after the pin falls rather
    // than at once: the core keeps a single clocked path, at the cost of that latency.
    // Idle values put clear_n high so that reset leaves no false clear behind.
    localparam logic [PIN_W-1:0] PIN_IDLE = {CLEAR_IDLE, {(PIN_W-1){PIN_RESET}}};

    logic [PIN_W-1:0] pins_async;
    logic [PIN_W-1:0] pins_s;

    // Order must match the field positions of the pin vector
    assign pins_async = {clear_n, shift_clk_in, latch_strobe, shift_mode,
                         serial_bit_in, parallel_in};

    pin_sync #(
        .WIDTH     (PIN_W),
        .RESET_VAL (PIN_IDLE)
    ) pin_sync_i (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .pin_async  (pins_async),
        .pin_synced (pins_s)
    );

    // ****************************************
    // Pin decode
    // ****************************************
    logic [W-1:0] par_s;
    logic         ser_s;
    logic         mode_s;
    logic         strobe_s;
    logic         shift_s;
    logic         clear_n_s;

    assign par_s     = pins_s[PIN_PAR_LSB +: W];
    assign ser_s     = pins_s[PIN_SER];
    assign mode_s    = pins_s[PIN_MODE];
    assign strobe_s  = pins_s[PIN_STROBE];
    assign shift_s   = pins_s[PIN_SHIFT];
    assign clear_n_s = pins_s[PIN_CLEAR_N];

    // ****************************************
    // State
    // ****************************************
    // Latch, stages and the two edge trackers live in one registered struct
    typedef struct packed {
        logic [W-1:0] latch;
        logic [W-1:0] stage;
        // Last synchronised level of the latch strobe and shift clock pins
        logic         strobe_d;
        logic         shift_d;
    } core_s;

    core_s state_r;
    core_s state_nxt;

    // Edge detectors start at the idle pin level, so no false edge follows reset.
    // An edge counts only when a high follows a low cycle; a pin that is high
    // for less than one ref_clk period may be missed.
    logic strobe_rise;
    logic shift_rise;

    assign strobe_rise = strobe_s & ~state_r.strobe_d;
    assign shift_rise  = shift_s & ~state_r.shift_d;

    // Next state: the latch follows its strobe; the stages take clear, load or shift
    always_comb begin
        state_nxt          = state_r;
        state_nxt.strobe_d = strobe_s;
        state_nxt.shift_d  = shift_s;
        // Latch is written only by its own strobe, never by the clear
        if (strobe_rise) begin
            state_nxt.latch = par_s;
        end
        // Clear wins over load and shift; a strobe in the same cycle still lands
        if (!clear_n_s) begin
            state_nxt.stage = STAGE_RESET;
        end else if (!mode_s) begin
            // Load is level-driven, as in the pin-level part; serial bit unused
            state_nxt.stage = state_r.latch;
        end else if (shift_rise) begin
            state_nxt.stage = {state_r.stage[W-2:0], ser_s};
        end
    end

    // Core reset clears the latch as well; only the clear pin spares it
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r <= '{latch: LATCH_RESET, stage: STAGE_RESET,
                         strobe_d: PIN_RESET, shift_d: PIN_RESET};
        end else begin
            state_r <= state_nxt;
        end
    end

    // Output comes straight from the last stage flop, never through logic
    assign serial_bit_out = state_r.stage[W-1];

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    // Checks watch the synchronised pins: they judge the core, not the crossing

    latch_capture_a: assert property (
        strobe_rise |=> state_r.latch == $past(par_s)
    ) else $error("latch did not capture parallel inputs");

    latch_hold_a: assert property (
        !strobe_rise |=> $stable(state_r.latch)
    ) else $error("latch changed without a strobe edge");

    shift_in_a: assert property (
        shift_rise && mode_s && clear_n_s |=> state_r.stage[0] == $past(ser_s)
    ) else $error("serial bit not taken into first stage");

    serial_ignored_a: assert property (
        !mode_s && clear_n_s && !strobe_rise ##1 !mode_s && clear_n_s
            |=> $stable(state_r.stage)
    ) else $error("stages moved while loading a steady latch");

    parallel_load_a: assert property (
        !mode_s && clear_n_s |=> state_r.stage == $past(state_r.latch)
    ) else $error("load mode did not copy the latch");

    stage_clear_a: assert property (
        !clear_n_s |=> state_r.stage == STAGE_RESET && serial_bit_out == 1'h0
    ) else $error("clear did not zero the stages");

    latch_survives_a: assert property (
        !clear_n_s && !strobe_rise |=> $stable(state_r.latch)
    ) else $error("clear disturbed the latch");

    stage_advance_a: assert property (
        shift_rise && mode_s && clear_n_s
            |=> state_r.stage[W-1:1] == $past(state_r.stage[W-2:0])
    ) else $error("stages did not advance on shift edge");

    out_follows_a: assert property (
        shift_rise && mode_s && clear_n_s |=> serial_bit_out == $past(state_r.stage[W-2])
    ) else $error("serial output not fed from second-to-last stage");

    shift_hold_a: assert property (
        mode_s && clear_n_s && !shift_rise |=> $stable(state_r.stage) && $stable(serial_bit_out)
    ) else $error("stages moved without a shift edge");

    // Priorities between clear, load and shift, and the width of the edge pulses
    // ****************************************
    // Checks on priorities and edge pulses
    // ****************************************
    strobe_pulse_a: assert property (
        strobe_rise
            |=> !strobe_rise
    ) else $error("latch strobe edge lasted more than one cycle");

    shift_pulse_a: assert property (
        shift_rise
            |=> !shift_rise
    ) else $error("shift edge lasted more than one cycle");

    load_blocks_shift_a: assert property (
        !mode_s && clear_n_s && shift_rise
            |=> state_r.stage == $past(state_r.latch)
    ) else $error("shift edge acted while loading");

    load_out_a: assert property (
        !mode_s && clear_n_s
            |=> serial_bit_out == $past(state_r.latch[W-1])
    ) else $error("serial output does not show the loaded word");

    clear_beats_shift_a: assert property (
        !clear_n_s && mode_s && shift_rise
            |=> state_r.stage == STAGE_RESET
    ) else $error("shift edge acted during a clear");

    clear_beats_load_a: assert property (
        !clear_n_s && !mode_s
            |=> state_r.stage == STAGE_RESET
    ) else $error("load acted during a clear");

    clear_strobe_a: assert property (
        !clear_n_s && strobe_rise
            |=> state_r.latch == $past(par_s)
    ) else $error("strobe during a clear did not load the latch");

    mode_entry_a: assert property (
        $rose(mode_s) && clear_n_s && !shift_rise
            |=> $stable(state_r.stage)
    ) else $error("entering shift mode disturbed the stages");

endmodule

// ### piso_latch_pkg.sv
// Constants shared by the latched serial shifter and its input synchroniser.
// Assumes a single 40 MHz core clock; all pins arrive asynchronously.
package piso_latch_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned SYNC_DEPTH  = 2;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [DATA_W-1:0] STAGE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] LATCH_RESET = 8'h00;
    localparam logic              PIN_RESET   = 1'h0;
    localparam logic              CLEAR_IDLE  = 1'h1;

    // ****************************************
    // Field positions in the synchronised pin vector
    // ****************************************
    localparam int unsigned PIN_PAR_LSB  = 0;
    localparam int unsigned PIN_SER      = 8;
    localparam int unsigned PIN_MODE     = 9;
    localparam int unsigned PIN_STROBE   = 10;
    localparam int unsigned PIN_SHIFT    = 11;
    localparam int unsigned PIN_CLEAR_N  = 12;
    localparam int unsigned PIN_W        = 13;

endpackage

// ### pin_sync.sv
// Two-flop synchroniser for a vector of asynchronous pins.
// Assumes each bit is independent; multi-bit words must be held stable by the sender.
`timescale 1ns/1ps
module pin_sync #(
    parameter int unsigned         WIDTH      = 1,
    parameter logic [WIDTH-1:0]    RESET_VAL  = '0
) (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic [WIDTH-1:0]  pin_async,
    output logic      [WIDTH-1:0]  pin_synced
);
    import piso_latch_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_s;

    sync_s state_r;
    sync_s state_nxt;

    // First flop feeds only the second one
    always_comb begin
        state_nxt.first  = pin_async;
        state_nxt.second = state_r.first;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r <= {RESET_VAL, RESET_VAL};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign pin_synced = state_r.second;
endmodule

// ### piso_host.sv
// Host model that drives every pin of the latched serial shifter.
// Assumes ref_clk from the bench; pins change 2 ns after a rising edge.
`timescale 1ns/1ps
module piso_host (
    input  wire logic        ref_clk,
    output logic [7:0]       parallel_in,
    output logic             serial_bit_in,
    output logic             shift_mode,
    output logic             latch_strobe,
    output logic             shift_clk_in,
    output logic             clear_n
);
    initial begin
        parallel_in = 8'h00;
        serial_bit_in = 1'h0;
        shift_mode = 1'h0;
        latch_strobe = 1'h0;
        shift_clk_in = 1'h0;
        clear_n = 1'h1;
    end
    // Levels stand 4 clocks: the pin synchronisers need 3 to act
    task automatic hold();
        repeat (4) @(posedge ref_clk);
        #2;
    endtask
    task automatic set(input logic m, input logic c);
        shift_mode = m;
        clear_n = c;
        hold();
    endtask
    task automatic strobe(input logic [7:0] w);
        parallel_in = w;
        hold();
        latch_strobe = 1'h1;
        hold();
        latch_strobe = 1'h0;
        // Hold time over: the data pins no longer show the word
        parallel_in = ~w;
        hold();
    endtask
    task automatic shift(input logic b);
        serial_bit_in = b;
        hold();
        shift_clk_in = 1'h1;
        hold();
        shift_clk_in = 1'h0;
        serial_bit_in = ~b;
        hold();
    endtask
endmodule

// ### test_latched_piso_shift_register.sv
// Self-checking bench for the latched serial shifter.
// Assumes the host model drives all pins; the output is read at settled times.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module test_latched_piso_shift_register;
    import piso_latch_pkg::*;
    logic              ref_clk = 1'h0;
    logic              reset = 1'h1;
    logic [DATA_W-1:0] parallel_in;
    logic              serial_bit_in, shift_mode, latch_strobe, shift_clk_in, clear_n;
    logic              serial_bit_out;
    int                n_fail = 0;
    int                checks_done = 0;
    always #12.5 ref_clk = ~ref_clk;
    piso_host piso_host_i (.ref_clk(ref_clk), .parallel_in(parallel_in),
        .serial_bit_in(serial_bit_in), .shift_mode(shift_mode),
        .latch_strobe(latch_strobe), .shift_clk_in(shift_clk_in), .clear_n(clear_n));
    latched_piso_shift_register latched_piso_shift_register_i (.ref_clk(ref_clk),
        .reset(reset), .parallel_in(parallel_in), .serial_bit_in(serial_bit_in),
        .shift_mode(shift_mode), .latch_strobe(latch_strobe),
        .shift_clk_in(shift_clk_in), .clear_n(clear_n), .serial_bit_out(serial_bit_out));
    // ****************************************
    // Scenarios
    // ****************************************
    // Latched word leaves msb first, then the serial bits follow 8 shifts later
    task automatic t_load_shift();
        logic [7:0] w;
        logic       e;
        w = 8'ha5;
        piso_host_i.strobe(w);
        `CHK(serial_bit_out, w[7])
        piso_host_i.set(1'h1, 1'h1);
        for (int k = 1; k <= 12; k++) begin
            piso_host_i.shift(k[0]);
            e = (k < 8) ? w[7-k] : 1'(k - 7);
            `CHK(serial_bit_out, e)
        end
    endtask
    // Load mode ignores serial data and shift edges; the output never moves meanwhile
    task automatic t_load_mode();
        int moved;
        moved = 0;
        piso_host_i.set(1'h0, 1'h1);
        piso_host_i.strobe(8'h5a);
        `CHK(serial_bit_out, 1'h0)
        for (int k = 0; k < 3; k++) begin
            fork
                piso_host_i.shift(1'h1);
                for (int c = 0; c < 12; c++) begin
                    @(posedge ref_clk);
                    #2;
                    if (serial_bit_out !== 1'h0) begin
                        moved++;
                    end
                end
            join
            `CHK(serial_bit_out, 1'h0)
        end
        `CHK(moved, 0)
    endtask
    // Clear zeroes the stages but the latched word comes back afterwards
    // Then a shift edge and a strobe during a clear: stages stay zero, latch still loads
    task automatic t_clear();
        piso_host_i.strobe(8'hc3);
        `CHK(serial_bit_out, 1'h1)
        piso_host_i.set(1'h0, 1'h0);
        `CHK(serial_bit_out, 1'h0)
        piso_host_i.set(1'h0, 1'h1);
        `CHK(serial_bit_out, 1'h1)
        piso_host_i.set(1'h1, 1'h0);
        piso_host_i.shift(1'h1);
        `CHK(serial_bit_out, 1'h0)
        piso_host_i.strobe(8'h3c);
        `CHK(serial_bit_out, 1'h0)
        piso_host_i.set(1'h0, 1'h1);
        `CHK(serial_bit_out, 1'h0)
    endtask
    task automatic conclude();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        #2;
        reset = 1'h0;
        piso_host_i.hold();
        `CHK(serial_bit_out, STAGE_RESET[7])
        t_load_shift();
        t_load_mode();
        t_clear();
        conclude();
    end
endmodule
